// ### hdl/bda_pkg.sv
// Constants, types and carriers shared by the broadcast data acquisition block
package bda_pkg;

	// ********************************
	// Addresses and line timing
	// ********************************
	localparam logic [7:0] I2C_WR_ADDR_LOW  = 8'h20;
	localparam logic [7:0] I2C_WR_ADDR_HIGH = 8'h22;
	localparam logic [7:0] I2C_RD_BIT       = 8'h01;
	localparam logic [8:0] VPS_LINE         = 9'h010;
	localparam logic [8:0] DEW_FIRST_LINE   = 9'h007;
	localparam logic [8:0] DEW_LAST_LINE    = 9'h016;
	localparam logic [8:0] LINE_MAX         = 9'h1ff;
	localparam int         XFER_BYTES       = 16;

	// ********************************
	// Byte numbers inside a data line
	// ********************************
	localparam logic [5:0] FIRST_BYTE      = 6'h01;
	localparam logic [5:0] RUNIN_LAST_BYTE = 6'h02;
	localparam logic [5:0] ADDR_BYTE_1     = 6'h04;
	localparam logic [5:0] ADDR_BYTE_2     = 6'h05;
	localparam logic [5:0] DESIG_BYTE      = 6'h06;
	localparam logic [5:0] TTX_LAST_BYTE   = 6'h2d;
	localparam logic [5:0] VPS_LAST_BYTE   = 6'h0f;
	localparam logic [2:0] BIT_LAST        = 3'h7;

	// ********************************
	// Packet address and designation codes
	// ********************************
	localparam logic [2:0] MAG8_CODE    = 3'h0;
	localparam logic [3:0] ROW30_HIGH   = 4'hf;
	localparam logic [3:0] HDR_ROW_HIGH = 4'h0;
	localparam logic [2:0] DESIG_FMT1   = 3'h0;
	localparam logic [2:0] DESIG_FMT2   = 3'h4;

	// ********************************
	// Reset and fill values
	// ********************************
	localparam logic [7:0] FILL_BYTE  = 8'hff;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	typedef enum logic [2:0] {KIND_VPS, KIND_FMT2, KIND_FMT1, KIND_HDR_A, KIND_HDR_B} bda_kind_t;
	typedef enum logic [1:0] {ST_IDLE, ST_RECV, ST_COMMIT} bda_acq_state_t;

	typedef struct packed {
		logic [3:0] test_bits;
		logic       header_order_select;
		logic       header_access_select;
		logic       operating_mode_select;
		logic       packet_format_select;
	} bda_ctrl_t;

	typedef struct packed {
		logic       start;
		logic       busy;
		logic       byte_ack;
		logic       ctrl_we;
		logic [7:0] ctrl_data;
	} bda_i2c_t;

	typedef struct packed {
		logic       hit;
		logic       nib;
		logic       hi;
		logic [3:0] slot;
	} bda_slot_t;

endpackage

// ### hdl/bda_hamming84.sv
// Hamming 8/4 decoder with single error correction
`timescale 1ns/1ps
module bda_hamming84 (
	input  wire logic [7:0] code,
	output logic      [3:0] nibble,
	output logic            ok
);
	// code[7] is the first bit on the line; nibble[3] is the first message bit
	logic p1, d1, p2, d2, p3, d3, p4, d4;
	logic a, b, c, d;

	// Parity checks are odd, so a good byte gives all ones
	always_comb begin
		{p1, d1, p2, d2, p3, d3, p4, d4} = code;
		a = p1 ^ d1 ^ d3 ^ d4;
		b = d1 ^ p2 ^ d2 ^ d4;
		c = d1 ^ d2 ^ p3 ^ d3;
		d = ^code;
		nibble = {d1, d2, d3, d4};
		ok = 1'b1;
		if (!d) begin
			// Single error: flip the data bit the failing checks point at
			if (!a && !b && !c) nibble[3] = ~d1;
			if (a && !b && !c)  nibble[2] = ~d2;
			if (!a && b && !c)  nibble[1] = ~d3;
			if (!a && !b && c)  nibble[0] = ~d4;
		end else if (!(a && b && c)) begin
			ok = 1'b0; // Double error cannot be repaired
		end
	end
endmodule

// ### hdl/bda_top.sv
// Acquisition and transfer register control of the broadcast data decoder
`timescale 1ns/1ps
module bda_top #(
	parameter logic [8:0] ACQ_VPS_LINE  = bda_pkg::VPS_LINE,
	parameter logic [8:0] DEW_FIRST     = bda_pkg::DEW_FIRST_LINE,
	parameter logic [8:0] DEW_LAST      = bda_pkg::DEW_LAST_LINE,
	parameter int         XFER_DEPTH    = bda_pkg::XFER_BYTES
) (
	input  wire logic              CLK,
	input  wire logic              RST,
	input  wire logic              LINK_CLK,
	input  wire logic              DATA_BIT,
	input  wire logic              LINE_SYNC,
	input  wire logic              FIELD_ID,
	input  wire logic              ADDRESS_SELECT_PIN,
	input  wire logic              TEST_MODE_PIN,
	input  wire bda_pkg::bda_i2c_t I2C_REQ,
	output logic                   DATA_READY_N,
	output logic                   FIRST_FIELD_FLAG,
	output logic                   TEST_MODE_ACTIVE,
	output logic                   SLICE_AVG_EN,
	output logic                   PLL_RATE_SEL,
	output logic [7:0]             I2C_WR_ADDR,
	output logic [7:0]             I2C_RD_ADDR,
	output logic [7:0]             I2C_READ_DATA,
	output bda_pkg::bda_ctrl_t     CTRL_REG
);
	// Layout tables below are fixed to sixteen bytes
	if (XFER_DEPTH != 16) begin : g_depth_check
		$error("XFER_DEPTH must be 16");
	end
	if (DEW_FIRST > DEW_LAST) begin : g_dew_check
		$error("DEW_FIRST must not exceed DEW_LAST");
	end

	// ********************************
	// Pin synchronisers
	// ********************************
	localparam int P_LCLK = 5;
	localparam int P_BIT  = 4;
	localparam int P_HS   = 3;
	localparam int P_FLD  = 2;
	localparam int P_ASEL = 1;
	localparam int P_TEST = 0;

	logic [5:0] sync1, sync2, sync3;
	logic [5:0] next_sync1, next_sync2, next_sync3;
	logic       dclk_rise, hsync_rise, field_edge;

	// Three flops per pin; edges are found only past the second flop
	always_comb begin
		next_sync1 = {LINK_CLK, DATA_BIT, LINE_SYNC, FIELD_ID, ADDRESS_SELECT_PIN, TEST_MODE_PIN};
		next_sync2 = sync1;
		next_sync3 = sync2;
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			sync1 <= 6'h00;
			sync2 <= 6'h00;
			sync3 <= 6'h00;
		end else begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
			sync3 <= next_sync3;
		end
	end

	assign dclk_rise  = sync2[P_LCLK] & ~sync3[P_LCLK];
	assign hsync_rise = sync2[P_HS] & ~sync3[P_HS];
	assign field_edge = sync2[P_FLD] ^ sync3[P_FLD];

	// ********************************
	// Control register and status pins
	// ********************************
	bda_pkg::bda_ctrl_t next_ctrl;
	logic [7:0]         next_wr_addr;
	logic               next_pll_sel, next_first_field, next_test;

	always_comb begin
		next_ctrl = CTRL_REG;
		if (I2C_REQ.ctrl_we) begin
			next_ctrl = I2C_REQ.ctrl_data;
		end
		next_pll_sel = next_ctrl.operating_mode_select;
		next_wr_addr = sync2[P_ASEL] ? bda_pkg::I2C_WR_ADDR_HIGH : bda_pkg::I2C_WR_ADDR_LOW;
		next_first_field = sync2[P_FLD];
		next_test = sync2[P_TEST];
	end

	// Control resets to zero, which is VPS mode
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			CTRL_REG         <= bda_pkg::CTRL_RESET;
			PLL_RATE_SEL     <= 1'b0;
			I2C_WR_ADDR      <= bda_pkg::I2C_WR_ADDR_LOW;
			I2C_RD_ADDR      <= bda_pkg::I2C_WR_ADDR_LOW | bda_pkg::I2C_RD_BIT;
			FIRST_FIELD_FLAG <= 1'b0;
			TEST_MODE_ACTIVE <= 1'b0;
		end else begin
			CTRL_REG         <= next_ctrl;
			PLL_RATE_SEL     <= next_pll_sel;
			I2C_WR_ADDR      <= next_wr_addr;
			I2C_RD_ADDR      <= next_wr_addr | bda_pkg::I2C_RD_BIT;
			FIRST_FIELD_FLAG <= next_first_field;
			TEST_MODE_ACTIVE <= next_test;
		end
	end

	// ********************************
	// Line counter
	// ********************************
	logic [8:0] line_cnt, next_line_cnt;

	// Field change restarts the count; the count saturates rather than wraps
	always_comb begin
		next_line_cnt = line_cnt;
		if (field_edge) begin
			next_line_cnt = 9'h000;
		end else if (hsync_rise && line_cnt != bda_pkg::LINE_MAX) begin
			next_line_cnt = line_cnt + 9'h001;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			line_cnt <= 9'h000;
		end else begin
			line_cnt <= next_line_cnt;
		end
	end

	// ********************************
	// Byte placement in the transfer register
	// ********************************
	function automatic bda_pkg::bda_slot_t slot_of(bda_pkg::bda_kind_t k, logic [5:0] n);
		bda_pkg::bda_slot_t s;
		s = '0;
		case (k)
			bda_pkg::KIND_VPS: begin
				if (n >= 6'h0b && n <= 6'h0e) s = '{1'b1, 1'b0, 1'b0, 4'(n - 6'h0b)};
				else if (n == 6'h05)          s = '{1'b1, 1'b0, 1'b0, 4'h4};
				else if (n == 6'h0f)          s = '{1'b1, 1'b0, 1'b0, 4'h5};
			end
			bda_pkg::KIND_FMT1: begin
				if (n >= 6'h0f && n <= 6'h15)      s = '{1'b1, 1'b0, 1'b0, 4'(n - 6'h0f)};
				else if (n == 6'h0d)               s = '{1'b1, 1'b0, 1'b0, 4'h7};
				else if (n == 6'h0e)               s = '{1'b1, 1'b0, 1'b0, 4'h8};
				else if (n >= 6'h16 && n <= 6'h19) s = '{1'b1, 1'b0, 1'b0, 4'(n - 6'h0d)};
			end
			bda_pkg::KIND_FMT2: begin
				// Two Hamming bytes per stored byte, first one in the high nibble; slot 6 takes byte 0x0d alone
				if (n >= 6'h10 && n <= 6'h17)      s = '{1'b1, 1'b1, ~n[0], 4'((n - 6'h10) >> 1)};
				else if (n == 6'h0e || n == 6'h0f) s = '{1'b1, 1'b1, ~n[0], 4'h4};
				else if (n == 6'h18 || n == 6'h19) s = '{1'b1, 1'b1, ~n[0], 4'h5};
				else if (n == 6'h0d)               s = '{1'b1, 1'b1, 1'b1, 4'h6};
			end
			bda_pkg::KIND_HDR_A: begin
				if (n >= 6'h26 && n <= 6'h2d)      s = '{1'b1, 1'b0, 1'b0, 4'(n - 6'h26)};
				else if (n >= 6'h1e && n <= 6'h25) s = '{1'b1, 1'b0, 1'b0, 4'(n - 6'h16)};
			end
			bda_pkg::KIND_HDR_B: begin
				if (n >= 6'h16 && n <= 6'h1d)      s = '{1'b1, 1'b0, 1'b0, 4'(n - 6'h16)};
				else if (n >= 6'h0e && n <= 6'h15) s = '{1'b1, 1'b0, 1'b0, 4'(n - 6'h06)};
			end
			default: s = '0;
		endcase
		return s;
	endfunction

	// ********************************
	// Line acquisition
	// ********************************
	bda_pkg::bda_acq_state_t state, next_state;
	bda_pkg::bda_kind_t      kind, next_kind;
	bda_pkg::bda_slot_t      slot;
	logic [5:0]              byte_num, next_byte_num;
	logic [2:0]              bit_cnt, next_bit_cnt;
	logic [7:0]              shreg, next_shreg, assembled;
	logic                    half, next_half, half_val, next_half_val;
	logic                    line_ok, next_line_ok, err, next_err, row0, next_row0;
	logic                    next_slice_avg, commit, win, is_hdr;
	logic [7:0]              shadow [16];
	logic [7:0]              next_shadow [16];
	logic [7:0]              xfer [16];
	logic [7:0]              next_xfer [16];
	logic [3:0]              nib;
	logic                    ham_ok;
	logic                    bit_val;

	bda_hamming84 u_ham (
		.code   (assembled),
		.nibble (nib),
		.ok     (ham_ok)
	);

	// VPS bits arrive as two half bits; the first half carries the value
	assign bit_val   = (kind == bda_pkg::KIND_VPS) ? half_val : sync2[P_BIT];
	assign assembled = {shreg[6:0], bit_val};
	assign is_hdr    = (kind == bda_pkg::KIND_HDR_A) || (kind == bda_pkg::KIND_HDR_B);
	assign slot      = slot_of(kind, byte_num);

	always_comb begin
		next_state    = state;
		next_kind     = kind;
		next_byte_num = byte_num;
		next_bit_cnt  = bit_cnt;
		next_shreg    = shreg;
		next_half     = half;
		next_half_val = half_val;
		next_line_ok  = line_ok;
		next_err      = err;
		next_row0     = row0;
		next_shadow   = shadow;
		next_xfer     = xfer;
		commit        = 1'b0;
		// VPS waits for line 16, PDC for any line of the entry window
		win = CTRL_REG.operating_mode_select ?
			(next_line_cnt >= DEW_FIRST && next_line_cnt <= DEW_LAST) :
			(next_line_cnt == ACQ_VPS_LINE);
		if (hsync_rise) begin
			// A new line restarts capture; a part line is simply dropped
			next_state = win ? bda_pkg::ST_RECV : bda_pkg::ST_IDLE;
			next_byte_num = bda_pkg::FIRST_BYTE;
			next_bit_cnt = 3'h0;
			next_half = 1'b0;
			next_line_ok = 1'b1;
			next_err = 1'b0;
			for (int i = 0; i < 16; i++) next_shadow[i] = bda_pkg::FILL_BYTE;
			if (!CTRL_REG.operating_mode_select) next_kind = bda_pkg::KIND_VPS;
			else if (!CTRL_REG.packet_format_select) next_kind = bda_pkg::KIND_FMT2;
			else if (!CTRL_REG.header_access_select) next_kind = bda_pkg::KIND_FMT1;
			else if (!CTRL_REG.header_order_select) next_kind = bda_pkg::KIND_HDR_A;
			else next_kind = bda_pkg::KIND_HDR_B;
		end else begin
			case (state)
				bda_pkg::ST_IDLE: begin
					next_state = bda_pkg::ST_IDLE;
				end
				bda_pkg::ST_RECV: begin
					if (dclk_rise && kind == bda_pkg::KIND_VPS && !half) begin
						next_half = 1'b1;
						next_half_val = sync2[P_BIT];
					end else if (dclk_rise) begin
						next_half = 1'b0;
						if (kind == bda_pkg::KIND_VPS && half_val == sync2[P_BIT]) begin
							next_err = 1'b1;
						end
						next_shreg = assembled;
						next_bit_cnt = bit_cnt + 3'h1;
						if (bit_cnt == bda_pkg::BIT_LAST) begin
							next_byte_num = byte_num + 6'h01;
							if (kind != bda_pkg::KIND_VPS) begin
								// magazine 8 row 30 with a service packet designation, or row 0 of any magazine for headers
								if (byte_num == bda_pkg::ADDR_BYTE_1) begin
									next_row0 = nib[0];
									if (!ham_ok || (!is_hdr && nib[3:1] != bda_pkg::MAG8_CODE))
										next_line_ok = 1'b0;
								end
								if (byte_num == bda_pkg::ADDR_BYTE_2 && (!ham_ok || row0 ||
									nib != (is_hdr ? bda_pkg::HDR_ROW_HIGH : bda_pkg::ROW30_HIGH)))
									next_line_ok = 1'b0;
								if (byte_num == bda_pkg::DESIG_BYTE && !is_hdr && (!ham_ok ||
									nib[2:0] != (kind == bda_pkg::KIND_FMT2 ?
									bda_pkg::DESIG_FMT2 : bda_pkg::DESIG_FMT1)))
									next_line_ok = 1'b0;
							end
							if (slot.hit && !slot.nib) begin
								next_shadow[slot.slot] = assembled;
							end else if (slot.hit && ham_ok && slot.hi) begin
								next_shadow[slot.slot][7:4] = nib;
							end else if (slot.hit && ham_ok) begin
								next_shadow[slot.slot][3:0] = nib;
							end
							if (byte_num == (kind == bda_pkg::KIND_VPS ?
								bda_pkg::VPS_LAST_BYTE : bda_pkg::TTX_LAST_BYTE))
								next_state = bda_pkg::ST_COMMIT;
						end
					end
				end
				bda_pkg::ST_COMMIT: begin
					next_state = bda_pkg::ST_IDLE;
					// a busy bus or test mode throws the line away
					if (line_ok && !err && !I2C_REQ.busy && !TEST_MODE_ACTIVE) begin
						next_xfer = shadow;
						commit = 1'b1;
					end
				end
				default: next_state = bda_pkg::ST_IDLE;
			endcase
		end
		// average over the whole VPS line, only the run-in on teletext
		next_slice_avg = (next_state == bda_pkg::ST_RECV) &&
			(next_kind == bda_pkg::KIND_VPS || next_byte_num <= bda_pkg::RUNIN_LAST_BYTE);
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state        <= bda_pkg::ST_IDLE;
			kind         <= bda_pkg::KIND_VPS;
			byte_num     <= 6'h00;
			bit_cnt      <= 3'h0;
			shreg        <= 8'h00;
			half         <= 1'b0;
			half_val     <= 1'b0;
			line_ok      <= 1'b0;
			err          <= 1'b0;
			row0         <= 1'b0;
			SLICE_AVG_EN <= 1'b0;
			for (int i = 0; i < 16; i++) begin
				shadow[i] <= bda_pkg::FILL_BYTE;
				xfer[i]   <= bda_pkg::FILL_BYTE;
			end
		end else begin
			state        <= next_state;
			kind         <= next_kind;
			byte_num     <= next_byte_num;
			bit_cnt      <= next_bit_cnt;
			shreg        <= next_shreg;
			half         <= next_half;
			half_val     <= next_half_val;
			line_ok      <= next_line_ok;
			err          <= next_err;
			row0         <= next_row0;
			SLICE_AVG_EN <= next_slice_avg;
			shadow       <= next_shadow;
			xfer         <= next_xfer;
		end
	end

	// ********************************
	// Host read side and data ready
	// ********************************
	logic [3:0] rd_ptr, next_rd_ptr;
	logic       next_ready_n;
	logic [7:0] next_rdata;

	// Read data lags the pointer by one cycle, far inside an I2C bit time
	always_comb begin
		next_rd_ptr = rd_ptr;
		if (I2C_REQ.start) begin
			next_rd_ptr = 4'h0;
		end else if (I2C_REQ.byte_ack) begin
			next_rd_ptr = rd_ptr + 4'h1;
		end
		next_rdata = xfer[rd_ptr];
		next_ready_n = DATA_READY_N;
		if (commit) begin
			next_ready_n = 1'b0;
		end else if (I2C_REQ.start) begin
			next_ready_n = 1'b1;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rd_ptr        <= 4'h0;
			I2C_READ_DATA <= bda_pkg::FILL_BYTE;
			DATA_READY_N  <= 1'b1;
		end else begin
			rd_ptr        <= next_rd_ptr;
			I2C_READ_DATA <= next_rdata;
			DATA_READY_N  <= next_ready_n;
		end
	end
endmodule

// ### dv/bda_chk.sv
// Checker of the acquisition block's port behaviour
`timescale 1ns/1ps
module bda_chk (
	input wire logic               CLK,
	input wire logic               RST,
	input wire logic               FIELD_ID,
	input wire logic               ADDRESS_SELECT_PIN,
	input wire logic               TEST_MODE_PIN,
	input wire bda_pkg::bda_i2c_t  I2C_REQ,
	input wire logic               DATA_READY_N,
	input wire logic               FIRST_FIELD_FLAG,
	input wire logic               TEST_MODE_ACTIVE,
	input wire logic               PLL_RATE_SEL,
	input wire logic [7:0]         I2C_WR_ADDR,
	input wire logic [7:0]         I2C_RD_ADDR,
	input wire bda_pkg::bda_ctrl_t CTRL_REG
);
	// ****************
	// Port relations
	// ****************
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	// Pins pass a synchroniser, so a level must rest a few cycles first
	addr_high_a: assert property (ADDRESS_SELECT_PIN [*5] |=>
		I2C_WR_ADDR == 8'h22 && I2C_RD_ADDR == 8'h23) else $error("address pair wrong, pin high");
	addr_low_a: assert property (!ADDRESS_SELECT_PIN [*5] |=>
		I2C_WR_ADDR == 8'h20 && I2C_RD_ADDR == 8'h21) else $error("address pair wrong, pin low");
	rate_mode_a: assert property (PLL_RATE_SEL == CTRL_REG.operating_mode_select)
		else $error("clock rate select differs from mode bit");
	ctrl_write_a: assert property (I2C_REQ.ctrl_we |=> CTRL_REG == $past(I2C_REQ.ctrl_data))
		else $error("control byte not taken");
	ctrl_hold_a: assert property (!I2C_REQ.ctrl_we |=> $stable(CTRL_REG))
		else $error("control changed without a write");
	ready_clear_a: assert property ($rose(DATA_READY_N) |-> $past(I2C_REQ.start))
		else $error("data ready released without a start");
	ready_hold_a: assert property (!DATA_READY_N && !I2C_REQ.start |=> !DATA_READY_N)
		else $error("data ready released early");
	// A full access must keep the register, and so the flag, untouched
	busy_block_a: assert property (I2C_REQ.busy [*3] |=> !$fell(DATA_READY_N))
		else $error("store during an access");
	field_flag_a: assert property (FIELD_ID [*4] |-> FIRST_FIELD_FLAG)
		else $error("first field flag low in first field");
	test_mode_a: assert property (TEST_MODE_PIN [*4] |-> TEST_MODE_ACTIVE)
		else $error("test mode not entered");
endmodule

bind bda_top bda_chk bda_chk_i (
	.CLK(CLK), .RST(RST), .FIELD_ID(FIELD_ID), .ADDRESS_SELECT_PIN(ADDRESS_SELECT_PIN),
	.TEST_MODE_PIN(TEST_MODE_PIN), .I2C_REQ(I2C_REQ), .DATA_READY_N(DATA_READY_N),
	.FIRST_FIELD_FLAG(FIRST_FIELD_FLAG), .TEST_MODE_ACTIVE(TEST_MODE_ACTIVE),
	.PLL_RATE_SEL(PLL_RATE_SEL), .I2C_WR_ADDR(I2C_WR_ADDR), .I2C_RD_ADDR(I2C_RD_ADDR),
	.CTRL_REG(CTRL_REG)
);

// ### dv/bda_host.sv
// Host model: the bus master's view of control writes and reads
`timescale 1ns/1ps
module bda_host (
	input  wire logic         CLK,
	output bda_pkg::bda_i2c_t req,
	output logic              rd_stb
);
	// ****************
	// Access tasks
	// ****************
	initial begin
		req = '0;
		rd_stb = 1'b0;
	end
	// Every access opens with a start and keeps busy up to its end
	task automatic open_access();
		@(posedge CLK);
		req.start <= 1'b1;
		req.busy <= 1'b1;
		@(posedge CLK);
		req.start <= 1'b0;
	endtask
	task automatic write_ctrl(input logic [7:0] v);
		open_access();
		req.ctrl_we <= 1'b1;
		req.ctrl_data <= v;
		@(posedge CLK);
		req.ctrl_we <= 1'b0;
		req.busy <= 1'b0;
	endtask
	// Strobe marks the cycle the data is valid; last byte is not acknowledged
	task automatic read(input int n);
		open_access();
		@(posedge CLK);
		for (int i = 0; i < n; i++) begin
			@(posedge CLK);
			rd_stb <= 1'b1;
			req.byte_ack <= (i != n - 1);
			@(posedge CLK);
			rd_stb <= 1'b0;
			req.byte_ack <= 1'b0;
			@(posedge CLK);
		end
		req.busy <= 1'b0;
	endtask
	task automatic hold_busy(input logic b);
		@(posedge CLK);
		req.busy <= b;
	endtask
endmodule

// ### dv/tb_top.sv
// Self-checking bench of the broadcast data acquisition block
`timescale 1ns/1ps
module tb_top;
	logic               CLK, RST, LINK_CLK, DATA_BIT, LINE_SYNC, FIELD_ID;
	logic               ADDRESS_SELECT_PIN, TEST_MODE_PIN, rd_stb;
	logic               DATA_READY_N, FIRST_FIELD_FLAG, TEST_MODE_ACTIVE, SLICE_AVG_EN, PLL_RATE_SEL;
	logic [7:0]         I2C_WR_ADDR, I2C_RD_ADDR, I2C_READ_DATA, keep0;
	bda_pkg::bda_i2c_t  I2C_REQ;
	bda_pkg::bda_ctrl_t CTRL_REG;
	logic [7:0]         ln [1:45];
	logic [7:0]         exp_q [$];
	logic [7:0]         codes [6] = '{8'h02, 8'h03, 8'h07, 8'h0f, 8'h0b, 8'h00};
	logic [7:0]         modes [4] = '{8'h07, 8'h0f, 8'h03, 8'h02};
	logic [3:0]         hn [13:25];
	logic [7:0]         e;
	int                 miscompares, n_checks, cycles;

	// ****************
	// Design, host and checking
	// ****************
	bda_top bda_top_i (.CLK(CLK), .RST(RST), .LINK_CLK(LINK_CLK), .DATA_BIT(DATA_BIT),
		.LINE_SYNC(LINE_SYNC), .FIELD_ID(FIELD_ID), .ADDRESS_SELECT_PIN(ADDRESS_SELECT_PIN),
		.TEST_MODE_PIN(TEST_MODE_PIN), .I2C_REQ(I2C_REQ), .DATA_READY_N(DATA_READY_N),
		.FIRST_FIELD_FLAG(FIRST_FIELD_FLAG), .TEST_MODE_ACTIVE(TEST_MODE_ACTIVE),
		.SLICE_AVG_EN(SLICE_AVG_EN), .PLL_RATE_SEL(PLL_RATE_SEL), .I2C_WR_ADDR(I2C_WR_ADDR),
		.I2C_RD_ADDR(I2C_RD_ADDR), .I2C_READ_DATA(I2C_READ_DATA), .CTRL_REG(CTRL_REG));
	bda_host bda_host_i (.CLK(CLK), .req(I2C_REQ), .rd_stb(rd_stb));

	// Clock of 50 ns
	initial begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end
	task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, e, g);
		end
	endtask
	task summarize;
		if (miscompares == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Each read strobe takes the oldest note off the queue
	always @(posedge CLK) begin
		if (rd_stb === 1'b1) cmp("read data", exp_q.pop_front(), I2C_READ_DATA);
	end
	// Ceiling well above the expected run of some 20000 cycles
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 60000) begin
			miscompares++;
			summarize();
		end
	end
	// Half a bit cell: link clock period of 8 cycles, still outside lines
	task automatic hb(input logic b);
		@(posedge CLK);
		DATA_BIT <= b;
		repeat (3) @(posedge CLK);
		LINK_CLK <= ~LINK_CLK;
		repeat (4) @(posedge CLK);
		LINK_CLK <= ~LINK_CLK;
	endtask
	// Field edge, count up to the wanted line, then the bytes, first bit on top
	task automatic send(input int lnum, input int nb, input bit vps, input int bad);
		logic b;
		@(posedge CLK);
		FIELD_ID <= ~FIELD_ID;
		repeat (lnum) begin
			repeat (3) @(posedge CLK);
			LINE_SYNC <= ~LINE_SYNC;
			repeat (3) @(posedge CLK);
			LINE_SYNC <= ~LINE_SYNC;
		end
		repeat (4) @(posedge CLK);
		for (int i = 1; i <= nb; i++) begin
			for (int j = 7; j >= 0; j--) begin
				if (j == 7 && (i == 2 || i == 10)) cmp("averaging", {7'h00, vps || i == 2}, {7'h00, SLICE_AVG_EN});
				b = ln[i][j];
				hb(b);
				if (vps) hb(~b ^ (i * 8 + j == bad));
			end
		end
		DATA_BIT <= ~DATA_BIT;
		repeat (12) @(posedge CLK);
		cmp("first field", {7'h00, FIELD_ID}, {7'h00, FIRST_FIELD_FLAG});
	endtask
	task automatic fill(input int a);
		for (int i = a; i <= 45; i++) ln[i] = 8'($urandom());
	endtask
	// Hamming 8/4 encoder with odd checks, first message bit sent second
	function automatic logic [7:0] ham(input logic [3:0] n);
		logic p1, p2, p3;
		p1 = ~(n[3] ^ n[1] ^ n[0]);
		p2 = ~(n[3] ^ n[2] ^ n[0]);
		p3 = ~(n[3] ^ n[2] ^ n[1]);
		return {p1, n[3], p2, n[2], p3, n[1], ~(^{p1, p2, p3, n}), n[0]};
	endfunction

	// ****************
	// Main sequence
	// ****************
	initial begin
		RST = 1'b1;
		LINK_CLK = 1'b0;
		DATA_BIT = 1'b0;
		LINE_SYNC = 1'b0;
		FIELD_ID = 1'b0;
		ADDRESS_SELECT_PIN = 1'b0;
		TEST_MODE_PIN = 1'b0;
		miscompares = 0;
		n_checks = 0;
		cycles = 0;
		void'($urandom(32'h9ed9));
		repeat (4) @(posedge CLK);
		RST <= 1'b0;
		repeat (2) @(posedge CLK);
		cmp("ready", 8'h01, {7'h00, DATA_READY_N});
		cmp("control", 8'h00, CTRL_REG);
		cmp("rate", 8'h00, {7'h00, PLL_RATE_SEL});
		cmp("write address", 8'h20, I2C_WR_ADDR);
		cmp("read address", 8'h21, I2C_RD_ADDR);
		repeat (16) exp_q.push_back(8'hff);
		bda_host_i.read(16);
		// A random pin level, then its inverse, so both pairs are seen
		for (int k = 0; k < 2; k++) begin
			ADDRESS_SELECT_PIN <= k ? ~ADDRESS_SELECT_PIN : 1'($urandom());
			repeat (6) @(posedge CLK);
			cmp("write address", ADDRESS_SELECT_PIN ? 8'h22 : 8'h20, I2C_WR_ADDR);
			cmp("read address", ADDRESS_SELECT_PIN ? 8'h23 : 8'h21, I2C_RD_ADDR);
		end
		// Every control code in turn, finishing back in VPS
		foreach (codes[k]) begin
			bda_host_i.write_ctrl(codes[k]);
			repeat (2) @(posedge CLK);
			cmp("control", codes[k], CTRL_REG);
			cmp("rate", {7'h00, codes[k][1]}, {7'h00, PLL_RATE_SEL});
		end
		// Good VPS line, read one past the end to see the pointer wrap
		fill(1);
		send(16, 15, 1'b1, -1);
		cmp("ready", 8'h00, {7'h00, DATA_READY_N});
		for (int i = 0; i < 4; i++) exp_q.push_back(ln[11 + i]);
		exp_q.push_back(ln[5]);
		exp_q.push_back(ln[15]);
		repeat (10) exp_q.push_back(8'hff);
		exp_q.push_back(ln[11]);
		keep0 = ln[11];
		bda_host_i.read(17);
		@(posedge CLK);
		cmp("ready", 8'h01, {7'h00, DATA_READY_N});
		// Broken biphase, a line under an access, a line in test mode: all dropped
		for (int k = 0; k < 3; k++) begin
			fill(1);
			if (k == 1) bda_host_i.hold_busy(1'b1);
			TEST_MODE_PIN <= (k == 2);
			send(16, 15, 1'b1, k == 0 ? 37 : -1);
			cmp("ready", 8'h01, {7'h00, DATA_READY_N});
			if (k == 2) cmp("test mode", 8'h01, {7'h00, TEST_MODE_ACTIVE});
			bda_host_i.hold_busy(1'b0);
			TEST_MODE_PIN <= 1'b0;
			exp_q.push_back(keep0);
			bda_host_i.read(1);
		end
		// PDC lines: header A, header B, format 1, then format 2 with one repairable
		// and one broken byte; magazine 8 is sent as zero in the coded address
		for (int m = 0; m < 4; m++) begin
			bda_host_i.write_ctrl(modes[m]);
			fill(7);
			ln[1] = 8'h55;
			ln[2] = 8'h55;
			ln[3] = 8'h27;
			ln[4] = ham(4'h0);
			ln[5] = ham(m < 2 ? 4'h0 : 4'hf);
			ln[6] = ham(m == 3 ? 4'h4 : 4'h0);
			for (int i = 13; i <= 25; i++) begin
				hn[i] = 4'($urandom());
				if (m == 3) ln[i] = ham(hn[i]) ^ (i == 16 ? 8'h40 : i == 25 ? 8'h60 : 8'h00);
			end
			send(7, 45, 1'b0, -1);
			cmp("ready", 8'h00, {7'h00, DATA_READY_N});
			for (int s = 0; s < 16; s++) begin
				case (m)
					0: e = ln[s < 8 ? 38 + s : 22 + s];
					1: e = ln[s < 8 ? 22 + s : 6 + s];
					2: e = s < 7 ? ln[15 + s] : s < 9 ? ln[6 + s] : s < 13 ? ln[13 + s] : 8'hff;
					default: begin
						if (s < 4) e = {hn[16 + 2 * s], hn[17 + 2 * s]};
						else if (s == 4) e = {hn[14], hn[15]};
						else if (s == 5) e = {hn[24], 4'hf};
						else if (s == 6) e = {hn[13], 4'hf};
						else e = 8'hff;
					end
				endcase
				exp_q.push_back(e);
			end
			bda_host_i.read(16);
		end
		// Reset in mid-run, out of PDC mode: control and transfer register start over
		RST <= 1'b1;
		repeat (2) @(posedge CLK);
		RST <= 1'b0;
		repeat (2) @(posedge CLK);
		cmp("control", 8'h00, CTRL_REG);
		cmp("rate", 8'h00, {7'h00, PLL_RATE_SEL});
		cmp("ready", 8'h01, {7'h00, DATA_READY_N});
		repeat (16) exp_q.push_back(8'hff);
		bda_host_i.read(16);
		summarize();
	end
endmodule
